/* File: rslc_blink_div.sv */
// Free-running divider that makes the visible activity blink phase
`timescale 1ns/1ps
module rslc_blink_div
    import rslc_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic enable,
    // Blink phase, toggles every half period
    output logic      phase_q
);

    localparam logic [BLINK_W-1:0] LAST = BLINK_W'(HALF_CYC - 1);

    logic [BLINK_W-1:0] count_q;

    // Runs regardless of activity so every blink has the same rhythm
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            phase_q <= 1'b0;
        end else if (enable) begin
            if (count_q == LAST) begin
                count_q <= '0;
                phase_q <= ~phase_q;   // see [R16]
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule

/* File: rslc_board.sv */
// Board model: strap resistors and internal pulls on the shared pins
`timescale 1ns/1ps
module rslc_board
    import rslc_pkg::*;
(
    // Fitted strap resistors and the levels they pull to
    input  wire logic [4:0] addr_fit,
    input  wire logic [4:0] addr_val,
    input  wire logic       adv_fit,
    input  wire logic       adv_val,
    // Device drive of the shared pins
    input  wire logic [4:0] addr_out,
    input  wire logic [4:0] addr_oe,
    input  wire logic       led_out,
    input  wire logic       led_oe,
    // Resolved pin levels
    output logic      [4:0] addr_pin,
    output logic            led_pin
);
    logic [4:0] addr_rest;
    logic       adv_rest;

    // A released pin settles to its resistor, else to the weak internal pull
    assign addr_rest = (addr_fit & addr_val) | (~addr_fit & STATION_ADDR_RST);
    assign adv_rest  = adv_fit ? adv_val : ADVERT_STRAP_RST;

    // Device drive wins only while its enable is high
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            addr_pin[i] = addr_oe[i] ? addr_out[i] : addr_rest[i];
        end
        led_pin = led_oe ? led_out : adv_rest;
    end
endmodule

/* File: rslc_pkg.sv */
// Shared constants, types and decodes for the reset, strap and indicator block
package rslc_pkg;

    // Clock rate
    localparam int CLK_PERIOD_NS = 5;

    // Station address strap: five bits, defaults follow the internal pulls
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] STATION_ADDR_RST = 5'h01;   // Bit 0 pulled up, bits 4..1 down
    localparam logic [4:0] ISOLATE_ADDR     = 5'h00;   // Strapped zero isolates the MAC side
    localparam logic       ADVERT_STRAP_RST = 1'h1;    // Internal pull-up on the shared pin

    // Cycles after reset release before the straps are captured
    localparam int         STRAP_SETTLE_CYC = 4;
    localparam int         SETTLE_W         = 3;

    // Activity blink half period, in its own unit and in cycles
    localparam int BLINK_HALF_NS  = 50_000_000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
    localparam int BLINK_W        = 24;

    // Indicator modes
    localparam logic LED_MODE_LINK     = 1'h0;   // Mode 1: link only
    localparam logic LED_MODE_LINK_ACT = 1'h1;   // Mode 2: link plus activity blink

    // Advertise field positions {100 FD, 100 HD, 10 FD, 10 HD}
    localparam int         ADV_10HD_POS = 0;
    localparam logic [3:0] ADV_ALL      = 4'hf;
    localparam logic [3:0] ADV_10HD     = 4'h1;

    // Captured strap values
    typedef struct packed {
        logic [4:0] addr;
        logic       advert;
    } rslc_strap_t;

    // Control register image: management address and isolation
    typedef struct packed {
        logic [4:0] addr;
        logic       isolate;
    } rslc_phyctl_t;

    // Mode control register image
    typedef struct packed {
        logic an_enable;
        logic speed_100;
        logic full_duplex;
    } rslc_mode_t;

    // Power-up sequence
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_CAPTURE,
        ST_RUN
    } rslc_state_t;

    // Advertise field implied by the advertised-mode strap
    function automatic logic [3:0] advert_bits(input logic advert);
        return advert ? ADV_ALL : ADV_10HD;
    endfunction

    // Mode control implied by the advertised-mode strap
    function automatic rslc_mode_t mode_bits(input logic advert);
        rslc_mode_t m;
        m.an_enable   = advert;
        m.speed_100   = advert;
        m.full_duplex = advert;
        return m;
    endfunction

    // Reset images of both registers
    localparam rslc_mode_t   MODE_RST   = '{an_enable: 1'h1, speed_100: 1'h1, full_duplex: 1'h1};
    localparam rslc_phyctl_t PHYCTL_RST = '{addr: STATION_ADDR_RST, isolate: 1'h0};

endpackage

/* File: rslc_sync.sv */
// Two flip-flop synchroniser for pin levels, with a reset value per bit
`timescale 1ns/1ps
module rslc_sync
    import rslc_pkg::*;
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic         enable,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else if (enable) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

/* File: rslc_tb.sv */
// Self-checking bench for the reset, strap and indicator block
`timescale 1ns/1ps
module testbench
    import rslc_pkg::*;
;
    typedef struct packed {
        logic [4:0] afit;
        logic [4:0] aval;
        logic       vfit;
        logic       vval;
        logic [4:0] eaddr;
        logic       eadv;
    } rslc_row_t;

    logic         clock, resetn, enable, col_func, adv_fit, adv_val, led_pin;
    logic         link_good, tx_active, rx_active, led_mode, sw_addr_wr;
    logic         link_indicator_out, link_indicator_oe, config_done;
    logic [3:0]   rxd_func, advert_reg;
    logic [4:0]   addr_fit, addr_val, addr_pin, sw_addr_data;
    logic [4:0]   station_addr_strap_out, station_addr_strap_oe;
    rslc_phyctl_t phy_control_reg;
    rslc_mode_t   mode_ctrl_reg;
    int           miscompares, cmp_count, edges;
    rslc_row_t    rows [6];

    // Ordinary strap cases; the two isolating ones last so software writes follow them
    initial begin
        rows[0] = '{5'h00, 5'h00, 1'h0, 1'h0, 5'h01, 1'h1};
        rows[1] = '{5'h1f, 5'h1f, 1'h1, 1'h1, 5'h1f, 1'h1};
        rows[2] = '{5'h1f, 5'h0a, 1'h0, 1'h0, 5'h0a, 1'h1};
        rows[3] = '{5'h1f, 5'h15, 1'h1, 1'h0, 5'h15, 1'h0};
        rows[4] = '{5'h01, 5'h00, 1'h1, 1'h1, 5'h00, 1'h1};
        rows[5] = '{5'h1f, 5'h00, 1'h1, 1'h0, 5'h00, 1'h0};
    end

    // Short blink count keeps the run brief
    rslc_top #(.BLINK_CYC(8)) u_rslc_top (
        .clock(clock), .resetn(resetn), .enable(enable),
        .station_addr_strap_in(addr_pin), .station_addr_strap_out(station_addr_strap_out),
        .station_addr_strap_oe(station_addr_strap_oe), .col_func(col_func),
        .rxd_func(rxd_func), .advert_mode_strap(led_pin),
        .link_indicator_out(link_indicator_out), .link_indicator_oe(link_indicator_oe),
        .link_good(link_good), .tx_active(tx_active), .rx_active(rx_active),
        .led_mode(led_mode), .sw_addr_wr(sw_addr_wr), .sw_addr_data(sw_addr_data),
        .phy_control_reg(phy_control_reg), .mode_ctrl_reg(mode_ctrl_reg),
        .advert_reg(advert_reg), .config_done(config_done)
    );

    rslc_board u_rslc_board (
        .addr_fit(addr_fit), .addr_val(addr_val), .adv_fit(adv_fit), .adv_val(adv_val),
        .addr_out(station_addr_strap_out), .addr_oe(station_addr_strap_oe),
        .led_out(link_indicator_out), .led_oe(link_indicator_oe),
        .addr_pin(addr_pin), .led_pin(led_pin)
    );

    // 200 MHz clock
    initial clock = 1'h0;
    always #2.5 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hold reset, check the reset image, release and wait for capture
    task automatic do_reset(input int n);
        resetn = 1'h0;
        cyc(n);
        chk({2'h0, phy_control_reg}, {2'h0, PHYCTL_RST});
        chk({mode_ctrl_reg, advert_reg}, {1'h0, MODE_RST, 4'hf});
        chk({station_addr_strap_oe, link_indicator_oe, config_done}, 8'h00);
        resetn = 1'h1;
        for (int k = 0; k < 20 && config_done !== 1'h1; k++) cyc(1);
        chk({station_addr_strap_oe, link_indicator_oe, config_done}, 8'h7f);
    endtask

    // Count indicator edges over a window; blink must toggle 3 or 4 times
    task automatic blink_window();
        logic prev;
        int   t;
        t    = 0;
        prev = led_pin;
        for (int k = 0; k < 32; k++) begin
            cyc(1);
            if (led_pin !== prev) t++;
            prev = led_pin;
        end
        chk(8'(t >= 3 && t <= 4), 8'h01);
    endtask

    // Watchdog sized well above the expected 1600 or so cycles
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done();
    end

    initial begin
        {resetn, col_func, rxd_func, link_good, tx_active, rx_active} = '0;
        {sw_addr_wr, sw_addr_data, addr_fit, addr_val, adv_fit, adv_val} = '0;
        enable   = 1'h1;
        led_mode = LED_MODE_LINK;
        cmp_count   = 0;
        miscompares = 0;
        do_reset(5);
        // Each row re-straps the board and resets with a 1 us low pulse
        foreach (rows[i]) begin
            {addr_fit, addr_val, adv_fit, adv_val} = {rows[i].afit, rows[i].aval,
                                                      rows[i].vfit, rows[i].vval};
            do_reset(200);
            chk({2'h0, phy_control_reg}, {2'h0, rows[i].eaddr, rows[i].eaddr == 5'h00});
            chk({5'h00, mode_ctrl_reg}, {5'h00, {3{rows[i].eadv}}});
            chk({4'h0, advert_reg}, {4'h0, rows[i].eadv ? ADV_ALL : ADV_10HD});
        end
        // Strap pins carry functional data once running
        col_func = 1'h1;
        rxd_func = 4'ha;
        cyc(2);
        chk({3'h0, addr_pin}, 8'h15);
        // Software address write keeps isolation as strapped
        sw_addr_wr   = 1'h1;
        sw_addr_data = 5'h07;
        cyc(1);
        sw_addr_wr = 1'h0;
        cyc(1);
        chk({2'h0, phy_control_reg}, {2'h0, 5'h07, 1'h1});
        {addr_fit, adv_fit} = '0;
        do_reset(200);
        sw_addr_wr   = 1'h1;
        sw_addr_data = 5'h00;
        cyc(1);
        sw_addr_wr = 1'h0;
        cyc(1);
        chk({2'h0, phy_control_reg}, 8'h00);
        // Mode 1 ignores activity and follows link
        {link_good, tx_active, rx_active} = 3'b111;
        for (int k = 0; k < 16; k++) begin
            cyc(1);
            chk({7'h0, led_pin}, 8'h01);
        end
        link_good = 1'h0;
        cyc(2);
        chk({7'h0, led_pin}, 8'h00);
        // Mode 2 steady with link alone, blinking with either activity source
        led_mode  = LED_MODE_LINK_ACT;
        {link_good, tx_active, rx_active} = 3'b100;
        for (int k = 0; k < 12; k++) begin
            cyc(1);
            chk({7'h0, led_pin}, 8'h01);
        end
        for (int a = 1; a <= 3; a++) begin
            {tx_active, rx_active} = 2'(a);
            cyc(2);
            blink_window();
        end
        {link_good, tx_active, rx_active} = 3'b000;
        cyc(2);
        chk({7'h0, led_pin}, 8'h00);
        test_done();
    end
endmodule

/* File: rslc_top.sv */
// Reset handling, strap capture and link indicator control
//
// Contract
// [R01] Mode 1: indicator on while link is good, off otherwise, no activity.
// [R02] Mode 2: indicator on with link, blinks while transmit or receive active.
// [R03] Reset held low at least 1 us; device then runs a full reset.
// [R04] Reset returns every internal register to its default value.
// [R05] Every reset re-captures all strap values, not only power-up.
// [R06] Strap pin levels are sampled around reset and select operating modes.
// [R07] After reset the strap pins go back to their functional output roles.
// [R08] Five station address strap bits are latched into the control register address.
// [R09] Every strapped address from 0 through 31 is accepted as management address.
// [R10] Strapped address zero puts the MAC-side interface into isolate mode.
// [R11] Writing address zero by software never selects isolation.
// [R12] Without straps the address defaults to one.
// [R13] Advertised-mode strap 0 advertises 10BASE-T half duplex only.
// [R14] Advertised-mode strap loads mode control and advertise registers at reset.
// [R15] Unconnected advertised-mode strap captures as 1.
// [R16] Blink comes from a free-running divider at a visible rate.
// [R17] Shared indicator pin stays undriven during reset, driven only afterwards.
`timescale 1ns/1ps
module rslc_top
    import rslc_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC
) (
    // Clock, reset and clock enable
    input  wire logic         clock,
    input  wire logic         resetn,
    input  wire logic         enable,
    // Station address strap pins, shared with collision and receive data
    input  wire logic [4:0]   station_addr_strap_in,
    output logic      [4:0]   station_addr_strap_out,
    output logic      [4:0]   station_addr_strap_oe,
    // Functional values for those pins once running
    input  wire logic         col_func,
    input  wire logic [3:0]   rxd_func,
    // Indicator pin, shared with the advertised-mode strap
    input  wire logic         advert_mode_strap,
    output logic              link_indicator_out,
    output logic              link_indicator_oe,
    // Link state and activity from the transceiver core
    input  wire logic         link_good,
    input  wire logic         tx_active,
    input  wire logic         rx_active,
    input  wire logic         led_mode,
    // Software write of the management address
    input  wire logic         sw_addr_wr,
    input  wire logic [4:0]   sw_addr_data,
    // Configuration images and status
    output rslc_phyctl_t      phy_control_reg,
    output rslc_mode_t        mode_ctrl_reg,
    output logic      [3:0]   advert_reg,
    output logic              config_done
);

    rslc_state_t          state_q;
    rslc_state_t          state_d;
    logic [SETTLE_W-1:0]  settle_q;
    logic [4:0]           addr_sync;
    logic                 advert_sync;
    logic                 blink_phase;
    logic                 activity;
    logic                 capture;
    logic                 running;
    rslc_strap_t          strap_now;

    // Pin levels come from outside the clock domain; reset values match the pulls
    rslc_sync #(
        .W       (ADDR_W),
        .RST_VAL (STATION_ADDR_RST)
    ) u_addr_sync (
        .clock  (clock),
        .resetn (resetn),
        .enable (enable),
        .d      (station_addr_strap_in),
        .q      (addr_sync)
    );

    rslc_sync #(
        .W       (1),
        .RST_VAL (ADVERT_STRAP_RST)
    ) u_advert_sync (
        .clock  (clock),
        .resetn (resetn),
        .enable (enable),
        .d      (advert_mode_strap),
        .q      (advert_sync)
    );

    // Free-running blink source
    rslc_blink_div #(
        .HALF_CYC (BLINK_CYC)
    ) u_blink (
        .clock   (clock),
        .resetn  (resetn),
        .enable  (enable),
        .phase_q (blink_phase)
    );

    assign strap_now = '{addr: addr_sync, advert: advert_sync};
    assign capture   = (state_q == ST_CAPTURE) && enable;
    assign running   = (state_q == ST_RUN);
    assign activity  = tx_active | rx_active;

    // Sequence restarts on every reset, so straps are re-read each time
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SETTLE: begin
                if (settle_q == SETTLE_W'(STRAP_SETTLE_CYC - 1)) begin
                    state_d = ST_CAPTURE;   // see [R05]
                end
            end
            ST_CAPTURE: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_SETTLE;
            end
        endcase
    end

    // Async reset acts at once; the board guarantees the minimum low time
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_SETTLE;   // see [R03]
        end else if (enable) begin
            state_q <= state_d;
        end
    end

    // Settle counter lets the synchronisers fill with the pulled pin levels
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            settle_q <= '0;
        end else if (enable && state_q == ST_SETTLE) begin
            settle_q <= settle_q + 1'b1;
        end
    end

    // Control register: strapped address, isolation only from the strap
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phy_control_reg <= PHYCTL_RST;   // see [R04] [R12]
        end else if (capture) begin
            phy_control_reg.addr    <= strap_now.addr;   // see [R06] [R08] [R09]
            phy_control_reg.isolate <= (strap_now.addr == ISOLATE_ADDR);   // see [R10]
        end else if (enable && running && sw_addr_wr) begin
            phy_control_reg.addr <= sw_addr_data;   // see [R11]
        end
    end

    // Mode control and advertise images both follow the advertised-mode strap
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_ctrl_reg <= MODE_RST;   // see [R15]
            advert_reg    <= ADV_ALL;
        end else if (capture) begin
            mode_ctrl_reg <= mode_bits(strap_now.advert);     // see [R14]
            advert_reg    <= advert_bits(strap_now.advert);   // see [R13]
        end
    end

    // Strap pins stay released until the capture, then carry their data again
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            station_addr_strap_out <= '0;
            station_addr_strap_oe  <= '0;
        end else if (enable) begin
            station_addr_strap_out <= {rxd_func, col_func};
            station_addr_strap_oe  <= {ADDR_W{state_d == ST_RUN}};   // see [R07]
        end
    end

    // Indicator: link level, and in mode 2 the blink phase masks it during activity
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link_indicator_out <= 1'b0;
            link_indicator_oe  <= 1'b0;
        end else if (enable) begin
            link_indicator_oe <= (state_d == ST_RUN);   // see [R17]
            if (led_mode == LED_MODE_LINK) begin
                link_indicator_out <= link_good;   // see [R01]
            end else begin
                link_indicator_out <= link_good & ~(activity & blink_phase);   // see [R02]
            end
        end
    end

    // Status flag for the rest of the device
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            config_done <= 1'b0;
        end else if (enable) begin
            config_done <= (state_d == ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_capture;
        capture;
    endsequence

    sequence s_released;
        link_indicator_oe && (station_addr_strap_oe == 5'h1f) && config_done;
    endsequence

    a_led_mode_one: assert property ( // see [R01]
        (enable && led_mode == LED_MODE_LINK)
        |=> (link_indicator_out == $past(link_good)))
        else $error("Mode 1 indicator does not follow link");

    a_led_blink_off: assert property ( // see [R02]
        (enable && led_mode == LED_MODE_LINK_ACT && link_good && activity && blink_phase)
        |=> !link_indicator_out)
        else $error("Mode 2 indicator not dark in blink phase");

    a_led_steady_on: assert property ( // see [R02]
        (enable && led_mode == LED_MODE_LINK_ACT && link_good && !activity)
        |=> link_indicator_out)
        else $error("Mode 2 indicator not on with idle link");

    a_capture_order: assert property ( // see [R05]
        (enable && state_q == ST_SETTLE && settle_q == 3'h0)
        |-> (state_q != ST_CAPTURE) [*3])
        else $error("Straps captured before synchronisers filled");

    a_addr_latch: assert property ( // see [R08]
        s_capture |=> (phy_control_reg.addr == $past(addr_sync)))
        else $error("Strapped address not latched");

    a_iso_strap: assert property ( // see [R10]
        s_capture |=> (phy_control_reg.isolate == ($past(addr_sync) == 5'h00)))
        else $error("Isolation does not match strapped address");

    a_sw_no_iso: assert property ( // see [R11]
        (running && !capture) |=> $stable(phy_control_reg.isolate))
        else $error("Isolation changed after capture");

    a_advert_load: assert property ( // see [R13]
        (s_capture ##0 !advert_sync)
        |=> (advert_reg == 4'h1) && !mode_ctrl_reg.an_enable)
        else $error("Strap 0 does not limit to 10BASE-T half duplex");

    a_pins_released: assert property ( // see [R17]
        !running |-> (!link_indicator_oe && station_addr_strap_oe == 5'h00))
        else $error("Shared pin driven before capture");

    a_pins_resume: assert property ( // see [R07]
        s_capture |=> s_released)
        else $error("Pins not driven after capture");

    a_blink_toggle: assert property ( // see [R16]
        (enable && running && $changed(blink_phase)) |=> !$changed(blink_phase))
        else $error("Blink phase toggles too fast");

endmodule
